// ==== lpoc_pkg.sv ====
package lpoc_pkg;
  // ----------------------------------------------------------------
  // Command opcodes and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] LPOC_OSC_FREQ_MASK = 8'hF0;
  localparam logic [7:0] LPOC_OSC_FREQ_OP   = 8'h70;
  localparam logic [7:0] LPOC_PWR_CTRL_OP   = 8'h25;
  localparam logic [7:0] LPOC_VRANGE_MASK   = 8'hF8;
  localparam logic [7:0] LPOC_VRANGE_OP     = 8'h20;
  localparam logic [7:0] LPOC_BIAS_MASK     = 8'hFC;
  localparam logic [7:0] LPOC_BIAS_OP       = 8'h50;
  localparam logic [7:0] LPOC_CONTRAST_OP   = 8'h81;
  localparam logic [7:0] LPOC_DISCH_MASK    = 8'hFE;
  localparam logic [7:0] LPOC_DISCH_OP      = 8'hEA;
  localparam logic [7:0] LPOC_OSC_ONOFF_OP  = 8'hAA;
  localparam logic [1:0] LPOC_BIAS_RESERVED = 2'h3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] LPOC_OSC_FREQ_RST  = 4'h0;
  localparam logic [2:0] LPOC_VRANGE_RST    = 3'h0;
  localparam logic [1:0] LPOC_BIAS_RST      = 2'h0;
  localparam logic [6:0] LPOC_CONTRAST_RST  = 7'h00;
  localparam logic [2:0] LPOC_PWR_RST       = 3'h0;
  // ----------------------------------------------------------------
  // Frame rate arithmetic
  // ----------------------------------------------------------------
  localparam int LPOC_FRAME_DIV   = 16;
  localparam int LPOC_FRAME_EXTRA = 3;
  // ----------------------------------------------------------------
  // Host register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] LPOC_REG_CMD    = 4'h0;
  localparam logic [3:0] LPOC_REG_STATUS = 4'h4;
  localparam logic [3:0] LPOC_REG_CFG0   = 4'h8;
  localparam logic [3:0] LPOC_REG_CFG1   = 4'hC;
  localparam int LPOC_CMD_DATA_SEL_BIT   = 8;
  // Frame line count from duty code: 5 + 4*code
  function automatic logic [6:0] lpoc_line_count(input logic [3:0] duty);
    lpoc_line_count = 7'h05 + {1'b0, duty, 2'b00};
  endfunction
  // Cycles of base clock per frame: 16 * (lines + 3)
  function automatic logic [10:0] lpoc_frame_div(input logic [3:0] duty);
    lpoc_frame_div = {lpoc_line_count(duty) + 7'h03, 4'h0};
  endfunction
endpackage

// ==== lpoc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lpoc_if;
  logic       wr_stb;     // One-cycle byte strobe
  logic       cmd_data_select; // 0 command, 1 data
  logic [7:0] wr_byte;    // Byte written
  modport host (output wr_stb, output cmd_data_select, output wr_byte);
  modport dev  (input wr_stb, input cmd_data_select, input wr_byte);
endinterface
`default_nettype wire

// ==== lpoc_frame_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpoc_frame_div
  import lpoc_pkg::*;
(
  input  wire logic       aclk,        // Clock
  input  wire logic       aresetn,     // Sync reset, active low
  input  wire logic       base_tick,   // One pulse per base clock period
  input  wire logic [3:0] duty_code,   // Duty select
  output logic            frame_tick   // One pulse per frame
);
  logic [10:0] cnt_r;
  wire  [10:0] limit = lpoc_frame_div(duty_code);
  wire         wrap  = base_tick && (cnt_r >= limit - 11'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r      <= 11'h000;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= wrap;
      if (wrap) begin
        cnt_r <= 11'h000;
      end else if (base_tick) begin
        cnt_r <= cnt_r + 11'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== lpoc_dev.sv ====
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lpoc_dev
  import lpoc_pkg::*;
(
  input  wire logic       aclk,                 // Clock
  input  wire logic       aresetn,              // Sync reset, active low
  lpoc_if.dev             bus,                  // Command byte link
  input  wire logic       master_mode,          // Device strapped as master
  input  wire logic       internal_osc_select,  // Internal oscillator chosen
  input  wire logic [3:0] duty_code,            // Duty from display timing
  input  wire logic       base_tick,            // Base clock period pulse
  output logic [3:0]      osc_freq_code,        // Oscillator frequency code
  output logic            osc_on,               // Internal oscillator run
  output logic            stepup_enable_bit,    // Step-up stage enable
  output logic            regulator_enable_bit, // Regulator enable
  output logic            drive_level_gen_enable_bit, // Drive level gen enable
  output logic [2:0]      voltage_range_code,   // Regulator range
  output logic [1:0]      bias_code,            // Bias ratio
  output logic [6:0]      contrast_value,       // Contrast level
  output logic            discharge_on,         // Capacitor discharge
  output logic            contrast_pending,     // Contrast entry active
  output logic            frame_tick            // Frame refresh pulse
);
  typedef enum logic [2:0] {
    LPOC_ST_IDLE     = 3'b001,
    LPOC_ST_PWR      = 3'b010,
    LPOC_ST_CONTRAST = 3'b100
  } lpoc_state_t;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  lpoc_state_t state_r;
  lpoc_state_t state_nxt;
  wire [7:0] b      = bus.wr_byte;
  wire       cmd    = bus.wr_stb && !bus.cmd_data_select;
  wire       dat    = bus.wr_stb && bus.cmd_data_select;
  wire       idle   = (state_r == LPOC_ST_IDLE);
  wire       dec_ok = cmd && idle;
  wire hit_freq  = dec_ok && ((b & LPOC_OSC_FREQ_MASK) == LPOC_OSC_FREQ_OP);
  wire hit_pwr   = dec_ok && (b == LPOC_PWR_CTRL_OP);
  // Power control opcode shares the range prefix; it is not a range write
  wire hit_vrng  = dec_ok && ((b & LPOC_VRANGE_MASK) == LPOC_VRANGE_OP) && (b != LPOC_PWR_CTRL_OP);
  wire hit_bias  = dec_ok && ((b & LPOC_BIAS_MASK) == LPOC_BIAS_OP);
  wire hit_cntr  = dec_ok && (b == LPOC_CONTRAST_OP);
  wire hit_disch = dec_ok && ((b & LPOC_DISCH_MASK) == LPOC_DISCH_OP);
  wire hit_osc   = dec_ok && ((b & LPOC_DISCH_MASK) == LPOC_OSC_ONOFF_OP);
  wire osc_allow = master_mode && internal_osc_select;
  wire bias_ok   = (b[1:0] != LPOC_BIAS_RESERVED);
  wire pwr_take  = (state_r == LPOC_ST_PWR) && dat;
  wire cntr_take = (state_r == LPOC_ST_CONTRAST) && bus.wr_stb;

  // ----------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LPOC_ST_IDLE: begin
        if (hit_pwr) begin
          state_nxt = LPOC_ST_PWR;
        end else if (hit_cntr) begin
          state_nxt = LPOC_ST_CONTRAST;
        end
      end
      LPOC_ST_PWR: begin
        if (bus.wr_stb) begin
          state_nxt = LPOC_ST_IDLE;
        end
      end
      LPOC_ST_CONTRAST: begin
        if (cntr_take) begin
          state_nxt = LPOC_ST_IDLE;
        end
      end
      default: state_nxt = LPOC_ST_IDLE;
    endcase
  end

  assign contrast_pending = (state_r == LPOC_ST_CONTRAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= LPOC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Held settings
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_freq_code <= LPOC_OSC_FREQ_RST;
      voltage_range_code <= LPOC_VRANGE_RST;
      bias_code <= LPOC_BIAS_RST;
      contrast_value <= LPOC_CONTRAST_RST;
      {stepup_enable_bit, regulator_enable_bit, drive_level_gen_enable_bit} <= LPOC_PWR_RST;
      discharge_on <= 1'b0;
      osc_on <= 1'b0;
    end else begin
      if (hit_freq) begin
        osc_freq_code <= b[3:0];
      end
      if (pwr_take) begin
        stepup_enable_bit          <= b[2];
        regulator_enable_bit       <= b[1];
        drive_level_gen_enable_bit <= b[0];
      end
      if (hit_vrng) begin
        voltage_range_code <= b[2:0];
      end
      if (hit_bias && bias_ok) begin
        bias_code <= b[1:0];
      end
      if (cntr_take) begin
        contrast_value <= b[6:0];
      end
      if (hit_disch) begin
        discharge_on <= b[0];
      end
      if (hit_osc && osc_allow) begin
        osc_on <= b[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame refresh
  // ----------------------------------------------------------------
  // frame divider
  lpoc_frame_div u_frame (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .base_tick  (base_tick),
    .duty_code  (duty_code),
    .frame_tick (frame_tick)
  );
endmodule
`default_nettype wire

// ==== lpoc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpoc_host
  import lpoc_pkg::*;
(
  input  wire logic        aclk,      // Clock
  input  wire logic        aresetn,   // Sync reset, active low
  lpoc_if.host             bus,       // Command byte link
  input  wire logic [3:0]  awaddr,    // AXI write address
  input  wire logic        awvalid,   // AXI
  output logic             awready,   // AXI
  input  wire logic [31:0] wdata,     // AXI
  input  wire logic [3:0]  wstrb,     // AXI
  input  wire logic        wvalid,    // AXI
  output logic             wready,    // AXI
  output logic [1:0]       bresp,     // AXI
  output logic             bvalid,    // AXI
  input  wire logic        bready,    // AXI
  input  wire logic [3:0]  araddr,    // AXI read address
  input  wire logic        arvalid,   // AXI
  output logic             arready,   // AXI
  output logic [31:0]      rdata,     // AXI
  output logic [1:0]       rresp,     // AXI
  output logic             rvalid,    // AXI
  input  wire logic        rready,    // AXI
  output logic             osc_running_flag, // Host belief oscillator on
  output logic             supply_active_flag // Host belief supply on
);
  logic        aw_r, w_r;
  logic [3:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic [8:0]  sent_r;
  logic        cpend_r;
  logic        ppend_r;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  assign awready = !aw_r && !bvalid;
  assign wready  = !w_r && !bvalid;
  wire   do_wr   = aw_r && w_r && !bvalid;
  wire   cmd_wr  = do_wr && (awa_r == LPOC_REG_CMD) && ws_r[0];
  wire   byte_ok = ppend_r || cpend_r || !wd_r[LPOC_CMD_DATA_SEL_BIT];
  wire   is_osc  = !wd_r[LPOC_CMD_DATA_SEL_BIT] && ((wd_r[7:0] & LPOC_DISCH_MASK) == LPOC_OSC_ONOFF_OP);
  wire   osc_stop_bad = is_osc && !wd_r[0] && supply_active_flag;
  wire   pwr_bad = !cpend_r && (wd_r[7:0] == LPOC_PWR_CTRL_OP) && !osc_running_flag
                   && !wd_r[LPOC_CMD_DATA_SEL_BIT];
  wire   send    = cmd_wr && byte_ok && !osc_stop_bad && !pwr_bad;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0; w_r <= 1'b0; awa_r <= 4'h0; wd_r <= 32'h0000_0000; ws_r <= 4'h0;
      bvalid <= 1'b0; bresp <= 2'h0;
      bus.wr_stb <= 1'b0; bus.cmd_data_select <= 1'b0; bus.wr_byte <= 8'h00;
      sent_r <= 9'h000; cpend_r <= 1'b0; ppend_r <= 1'b0;
      osc_running_flag <= 1'b0; supply_active_flag <= 1'b0;
    end else begin
      bus.wr_stb <= send;
      if (awvalid && awready) begin
        aw_r <= 1'b1;
        awa_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_r <= 1'b1;
        wd_r <= wdata;
        ws_r <= wstrb;
      end
      if (do_wr) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awa_r == LPOC_REG_CMD && send) ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (send) begin
        bus.wr_byte <= wd_r[7:0];
        bus.cmd_data_select <= wd_r[LPOC_CMD_DATA_SEL_BIT] || cpend_r ? wd_r[LPOC_CMD_DATA_SEL_BIT] : 1'b0;
        sent_r <= wd_r[8:0];
        if (cpend_r) begin
          cpend_r <= 1'b0;
        end else if (ppend_r) begin
          ppend_r <= 1'b0;
          supply_active_flag <= |wd_r[2:0];
        end else if (wd_r[7:0] == LPOC_CONTRAST_OP) begin
          cpend_r <= 1'b1;
        end else if (wd_r[7:0] == LPOC_PWR_CTRL_OP) begin
          ppend_r <= 1'b1;
        end else if (is_osc) begin
          osc_running_flag <= wd_r[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign arready = !rvalid;
  wire [31:0] rd_mux = (araddr == LPOC_REG_STATUS) ?
                       {27'h0, cpend_r, ppend_r, supply_active_flag, osc_running_flag, 1'b0} :
                       (araddr == LPOC_REG_CMD) ? {23'h0, sent_r} : 32'h0000_0000;
  wire        rd_ok  = (araddr == LPOC_REG_STATUS) || (araddr == LPOC_REG_CMD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== lpoc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpoc_props
  import lpoc_pkg::*;
(
  input wire logic       aclk,                       // Clock
  input wire logic       aresetn,                    // Sync reset
  input wire logic       wr_stb,                     // Strobe
  input wire logic       cmd_data_select,            // Byte kind
  input wire logic [7:0] wr_byte,                    // Byte
  input wire logic [3:0] osc_freq_code,              // Freq
  input wire logic       stepup_enable_bit,          // Step-up
  input wire logic       regulator_enable_bit,       // Regulator
  input wire logic       drive_level_gen_enable_bit, // Level gen
  input wire logic [2:0] voltage_range_code,         // Range
  input wire logic [1:0] bias_code,                  // Bias
  input wire logic [6:0] contrast_value,             // Contrast
  input wire logic       discharge_on,               // Discharge
  input wire logic       contrast_pending            // Entry state
);
  // ----
  // Pair tracking
  // ----
  logic       pp_r;
  logic [7:0] byte_r;
  wire        cmd_ok = wr_stb && !cmd_data_select && !contrast_pending && !pp_r;
  wire        pp_nxt = wr_stb ? (cmd_ok && wr_byte == LPOC_PWR_CTRL_OP) : pp_r;
  always_ff @(posedge aclk) begin
    pp_r   <= aresetn && pp_nxt;
    byte_r <= wr_byte;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_freq_store: assert property (
    cmd_ok && (wr_byte & LPOC_OSC_FREQ_MASK) == LPOC_OSC_FREQ_OP |=> osc_freq_code == byte_r[3:0])
    else $error("freq code not stored");
  a_freq_reset: assert property ($rose(aresetn) |-> osc_freq_code == LPOC_OSC_FREQ_RST)
    else $error("freq code not reset");
  a_range_reset: assert property ($rose(aresetn) |-> voltage_range_code == LPOC_VRANGE_RST)
    else $error("range not reset");
  a_range_store: assert property (
    cmd_ok && wr_byte != LPOC_PWR_CTRL_OP && (wr_byte & LPOC_VRANGE_MASK) == LPOC_VRANGE_OP
    |=> voltage_range_code == byte_r[2:0]) else $error("range not stored");
  a_bias_store: assert property (
    cmd_ok && (wr_byte & LPOC_BIAS_MASK) == LPOC_BIAS_OP && wr_byte[1:0] != LPOC_BIAS_RESERVED
    |=> bias_code == byte_r[1:0]) else $error("bias not stored");
  a_bias_keep: assert property (
    cmd_ok && wr_byte == (LPOC_BIAS_OP | 8'h03) |=> $stable(bias_code)) else $error("bias changed");
  a_con_enter: assert property (cmd_ok && wr_byte == LPOC_CONTRAST_OP |=> contrast_pending)
    else $error("no contrast entry");
  a_con_value: assert property (
    wr_stb && contrast_pending |=> contrast_value == byte_r[6:0]) else $error("contrast wrong");
  a_con_leave: assert property (wr_stb && contrast_pending |=> !contrast_pending[*2])
    else $error("entry not left");
  a_power_set: assert property (
    wr_stb && pp_r && cmd_data_select
    |=> {stepup_enable_bit, regulator_enable_bit, drive_level_gen_enable_bit} == byte_r[2:0])
    else $error("power bits wrong");
  a_disch_set: assert property (
    cmd_ok && (wr_byte & LPOC_DISCH_MASK) == LPOC_DISCH_OP |=> discharge_on == byte_r[0])
    else $error("discharge wrong");
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lpoc_pkg::*;
;
  typedef struct {string nm; logic [31:0] v;} lpoc_note_t;
  typedef struct packed {
    logic [3:0] fq; logic on; logic [2:0] pw; logic [2:0] vr; logic [1:0] bi; logic [6:0] co; logic di; logic pd;
  } lpoc_dev_t;
  logic        aclk = 1'b0, aresetn = 1'b0, master_mode = 1'b0, internal_osc_select = 1'b1, base_tick = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, snap_req = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, duty_code = 4'hF;
  logic [31:0] wdata = 32'h0, seed = 32'hD51CEE98, rdata, got;
  logic        awready, wready, bvalid, arready, rvalid, osc_on, stepup_enable_bit, regulator_enable_bit;
  logic        drive_level_gen_enable_bit, discharge_on, contrast_pending;
  logic [1:0]  bresp, bias_code;
  logic [3:0]  osc_freq_code;
  logic [2:0]  voltage_range_code;
  logic [6:0]  contrast_value;
  int          err_count = 0, n_tests = 0;
  lpoc_note_t  q[$];
  lpoc_note_t  t;
  lpoc_dev_t   e;
  wire logic [21:0] dev_v = {osc_freq_code, osc_on, stepup_enable_bit, regulator_enable_bit,
    drive_level_gen_enable_bit, voltage_range_code, bias_code, contrast_value, discharge_on, contrast_pending};
  always #2.5 aclk = ~aclk;
  lpoc_if i_lpoc_if();
  lpoc_host i_lpoc_host(.aclk, .aresetn, .bus(i_lpoc_if.host), .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp(), .rvalid,
    .rready, .osc_running_flag(), .supply_active_flag());
  lpoc_dev i_lpoc_dev(.aclk, .aresetn, .bus(i_lpoc_if.dev), .master_mode, .internal_osc_select, .duty_code,
    .base_tick, .osc_freq_code, .osc_on, .stepup_enable_bit, .regulator_enable_bit, .drive_level_gen_enable_bit,
    .voltage_range_code, .bias_code, .contrast_value, .discharge_on, .contrast_pending, .frame_tick());
  lpoc_props i_lpoc_props(.aclk, .aresetn, .wr_stb(i_lpoc_if.wr_stb), .cmd_data_select(i_lpoc_if.cmd_data_select),
    .wr_byte(i_lpoc_if.wr_byte), .osc_freq_code, .stepup_enable_bit, .regulator_enable_bit,
    .drive_level_gen_enable_bit, .voltage_range_code, .bias_code, .contrast_value, .discharge_on, .contrast_pending);
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge aclk) begin
    seed      <= xs(seed);
    base_tick <= seed[0];
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    err_count++;
    $display("Error wait expected handshake seen timeout");
    tally_and_finish();
  endtask
  task automatic note(input string nm, input logic [31:0] v);
    lpoc_note_t n;
    n.nm = nm;
    n.v  = v;
    q.push_back(n);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    note("bresp", {30'h0, er});
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) hang();
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ex);
    int n;
    @(posedge aclk);
    note("rdata", ex);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) hang();
  endtask
  task automatic snap();
    note("settings", {10'h0, e});
    snap_req <= 1'b1;
    @(posedge aclk);
    snap_req <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic s, input logic [1:0] er);
    axi_wr(LPOC_REG_CMD, {23'h0, s, b}, er);
    repeat (3) @(posedge aclk);
    snap();
  endtask
  // ----
  // Result watcher
  // ----
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready) || snap_req) begin
      t   = q.pop_front();
      got = snap_req ? {10'h0, dev_v} : (bvalid && bready) ? {30'h0, bresp} : rdata;
      n_tests++;
      if (got !== t.v) begin
        err_count++;
        $display("Error %s expected %h seen %h", t.nm, t.v, got);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    hang();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    int i;
    logic [7:0] w;
    e = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    snap();
    axi_rd(LPOC_REG_STATUS, 32'h0);
    for (i = 0; i < 4; i++) begin
      e.fq = seed[7:4];
      send({4'h7, e.fq}, 1'b0, 2'h0);
    end
    e.fq = 4'hF;
    send(8'h7F, 1'b0, 2'h0);
    $display("Test frequency done");
    send(LPOC_PWR_CTRL_OP, 1'b0, 2'h2);
    send(8'h05, 1'b1, 2'h2);
    send(8'hAB, 1'b0, 2'h0);
    master_mode <= 1'b1;
    e.on = 1'b1;
    send(8'hAB, 1'b0, 2'h0);
    send(LPOC_PWR_CTRL_OP, 1'b0, 2'h0);
    e.pw = 3'h5;
    send(8'h05, 1'b1, 2'h0);
    axi_rd(LPOC_REG_STATUS, 32'h6);
    send(8'hAA, 1'b0, 2'h2);
    axi_rd(LPOC_REG_CMD, 32'h105);
    $display("Test power done");
    for (i = 0; i < 8; i++) begin
      if (i != 5) begin
        e.vr = i[2:0];
        send({5'h04, i[2:0]}, 1'b0, 2'h0);
      end
    end
    for (i = 0; i < 4; i++) begin
      if (i < 3) e.bi = i[1:0];
      send({6'h14, i[1:0]}, 1'b0, 2'h0);
    end
    $display("Test range and bias done");
    e.pd = 1'b1;
    send(LPOC_CONTRAST_OP, 1'b0, 2'h0);
    e.pd = 1'b0;
    e.co = 7'h73;
    send(8'hF3, 1'b0, 2'h0);
    w = seed[15:8];
    e.pd = 1'b1;
    send(LPOC_CONTRAST_OP, 1'b0, 2'h0);
    e.pd = 1'b0;
    e.co = w[6:0];
    send(w, 1'b1, 2'h0);
    e.di = 1'b1;
    send(8'hEB, 1'b0, 2'h0);
    e.di = 1'b0;
    send(8'hEA, 1'b0, 2'h0);
    axi_wr(4'h8, 32'h0, 2'h2);
    axi_rd(4'h8, 32'h0);
    $display("Test contrast and discharge done");
    @(posedge aclk);
    aresetn <= 1'b0;
    e = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    snap();
    $display("Test second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
